// ==== include/pss_pkg.sv ====
// package of constants, types and helpers for the preset speed selector
package pss_pkg;

    // geometry of the preset bank
    localparam int PSS_NUM_PRESETS = 8;
    localparam int PSS_IDX_W       = 3;
    localparam int PSS_VAL_W       = 16;
    localparam int PSS_ADDR_W      = 8;
    localparam int PSS_DATA_W      = 32;

    // preset values are signed tenths of a percent
    localparam logic signed [15:0] PSS_VAL_MIN   = -16'sd1000;
    localparam logic signed [15:0] PSS_VAL_MAX   = 16'sd1000;
    localparam logic signed [15:0] PSS_VAL_RESET = 16'sd0;

    // select input positions within the index
    localparam int PSS_SEL0_POS = 0;
    localparam int PSS_SEL1_POS = 1;
    localparam int PSS_SEL2_POS = 2;

    // register byte offsets, one aligned word each
    localparam logic [7:0] PSS_OFF_PRESET0 = 8'h00;
    localparam logic [7:0] PSS_OFF_PRESET7 = 8'h1C;
    localparam logic [7:0] PSS_OFF_INDEX   = 8'h20;
    localparam logic [7:0] PSS_OFF_VALUE   = 8'h24;

    // field layout of the value and index words
    localparam int PSS_VAL_LSB = 0;
    localparam int PSS_IDX_LSB = 0;

    // reset values of the monitors and bus outputs
    localparam logic [2:0]  PSS_IDX_RESET  = 3'h0;
    localparam logic [31:0] PSS_DATA_RESET = 32'h0000_0000;

    typedef logic signed [15:0] pss_val_t;
    typedef logic [2:0]         pss_idx_t;
    typedef logic [7:0][15:0]   pss_bank_t;

    // limit a written value to the legal preset range
    function automatic pss_val_t pss_clamp(input logic [15:0] raw);
        pss_val_t v;
        v = pss_val_t'(raw);
        if (v > PSS_VAL_MAX) begin
            return PSS_VAL_MAX;
        end
        if (v < PSS_VAL_MIN) begin
            return PSS_VAL_MIN;
        end
        return v;
    endfunction

    // build the binary index from the three select lines
    function automatic pss_idx_t pss_index(input logic s2,
                                           input logic s1,
                                           input logic s0);
        pss_idx_t i;
        i = PSS_IDX_RESET;
        i[PSS_SEL0_POS] = s0;
        i[PSS_SEL1_POS] = s1;
        i[PSS_SEL2_POS] = s2;
        return i;
    endfunction

endpackage

// ==== include/pss_sel_if.sv ====
// carrier between the register bank and the selector stage
`timescale 1ns/1ps
interface pss_sel_if;
    import pss_pkg::*;

    pss_bank_t bank;
    pss_idx_t  index_in;
    pss_idx_t  index_q;
    pss_val_t  value_q;

    // the bank owner drives presets and raw index
    modport owner (
        output bank,
        output index_in,
        input  index_q,
        input  value_q
    );

    // the selector registers index and chosen value
    modport sel (
        input  bank,
        input  index_in,
        output index_q,
        output value_q
    );
endinterface

// ==== src/pss_mux.sv ====
// selector stage: registers the index and the preset it picks
`timescale 1ns/1ps
module pss_mux
    import pss_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // bank and index from the owner
    pss_sel_if.sel    sel_bus
);

    pss_val_t chosen;

    // one-of-eight pick, combinational before the output register
    assign chosen = pss_val_t'(sel_bus.bank[sel_bus.index_in]);

    // index register, one clock of latency
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sel_bus.index_q <= PSS_IDX_RESET;
        end else begin
            sel_bus.index_q <= sel_bus.index_in;
        end
    end

    // value register, shares the index latency so both stay aligned
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sel_bus.value_q <= PSS_VAL_RESET;
        end else begin
            sel_bus.value_q <= chosen;
        end
    end

    // value follows any change of bank or index one clock later
    property p_value_lag;
        @(posedge mclk) disable iff (!resetn)
        1'b1 |=> (sel_bus.value_q == $past(chosen));
    endproperty
    a_value_lag: assert property (p_value_lag)
        else $error("chosen value not registered one clock later");

endmodule

// ==== src/pss_top.sv ====
// preset speed selector: preset bank, apb slave and selector stage
// values are in tenths of a percent, so the legal span is -1000..+1000.
// writes outside that span are clamped rather than refused, so the
// reference can never leave its range even on a careless write.
`timescale 1ns/1ps
module pss_top
    import pss_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // select lines from the digital inputs
    input  wire logic        sel0,
    input  wire logic        sel1,
    input  wire logic        sel2,
    // reference path and monitors
    output logic      [15:0] ref_out,
    output logic      [2:0]  index_out
);

    pss_sel_if sel_bus ();

    pss_val_t   preset [PSS_NUM_PRESETS];
    logic       setup_phase;
    logic       access_phase;
    logic       wr_take;
    logic       addr_preset;
    logic [2:0] addr_slot;
    logic       addr_mapped;
    logic [15:0] merged;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    // address decode, shared by the read and write paths
    assign addr_preset = (paddr <= PSS_OFF_PRESET7) && (paddr[1:0] == 2'b00);
    assign addr_slot   = paddr[4:2];
    assign addr_mapped = addr_preset
                       || (paddr == PSS_OFF_INDEX)
                       || (paddr == PSS_OFF_VALUE);

    // phases of an apb transfer; the slave never inserts wait states
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign pready       = access_phase;
    assign wr_take      = access_phase && pwrite && addr_preset;

    // merge byte lanes with the stored value before clamping
    always_comb begin
        merged = preset[addr_slot];
        if (pstrb[0]) begin
            merged[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            merged[15:8] = pwdata[15:8];
        end
    end

    // preset bank, written at the access edge only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < PSS_NUM_PRESETS; i++) begin
                preset[i] <= PSS_VAL_RESET;
            end
        end else if (wr_take) begin
            preset[addr_slot] <= pss_clamp(merged);
        end
    end

    // read mux; monitors are read-only and a write there is ignored
    always_comb begin
        next_prdata  = PSS_DATA_RESET;
        next_pslverr = 1'b0;
        if (addr_preset) begin
            next_prdata[PSS_VAL_LSB +: PSS_VAL_W] = preset[addr_slot];
        end else if (paddr == PSS_OFF_INDEX) begin
            next_prdata[PSS_IDX_LSB +: PSS_IDX_W] = sel_bus.index_q;
        end else if (paddr == PSS_OFF_VALUE) begin
            next_prdata[PSS_VAL_LSB +: PSS_VAL_W] = sel_bus.value_q;
        end else begin
            next_pslverr = 1'b1;
        end
        if (pwrite) begin
            next_prdata = PSS_DATA_RESET;
        end
    end

    // read data and error are captured in the setup cycle, so the
    // access phase presents flopped data with no wait state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= PSS_DATA_RESET;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= next_prdata;
            pslverr <= next_pslverr && !addr_mapped;
        end
    end

    // feed the selector stage
    always_comb begin
        for (int i = 0; i < PSS_NUM_PRESETS; i++) begin
            sel_bus.bank[i] = preset[i];
        end
    end
    assign sel_bus.index_in = pss_index(sel2, sel1, sel0);

    pss_mux u_mux (
        .mclk    (mclk),
        .resetn  (resetn),
        .sel_bus (sel_bus.sel)
    );

    // outputs come straight from the selector's flip-flops
    assign ref_out   = sel_bus.value_q;
    assign index_out = sel_bus.index_q;

    // a preset write never goes past the legal range
    property p_preset_range;
        @(posedge mclk) disable iff (!resetn)
        wr_take |=> (preset[$past(addr_slot)] >= PSS_VAL_MIN)
                 && (preset[$past(addr_slot)] <= PSS_VAL_MAX);
    endproperty
    a_preset_range: assert property (p_preset_range)
        else $error("preset left the legal range after a write");

    // an in-range full write lands unchanged
    property p_preset_store;
        @(posedge mclk) disable iff (!resetn)
        (wr_take && (pstrb[1:0] == 2'b11)
         && ($signed(pwdata[15:0]) >= PSS_VAL_MIN)
         && ($signed(pwdata[15:0]) <= PSS_VAL_MAX))
        |=> (preset[$past(addr_slot)] == $past(pwdata[15:0]));
    endproperty
    a_preset_store: assert property (p_preset_store)
        else $error("in-range preset write not stored as written");

    // output equals the preset chosen by the index it shows
    property p_ref_match;
        @(posedge mclk) disable iff (!resetn)
        (!$past(wr_take)) |-> (ref_out == preset[index_out]);
    endproperty
    a_ref_match: assert property (p_ref_match)
        else $error("reference output differs from indexed preset");

    // select 0 reaches index bit 0 one clock later
    property p_sel0_bit;
        @(posedge mclk) disable iff (!resetn)
        1'b1 |=> (index_out[0] == $past(sel0));
    endproperty
    a_sel0_bit: assert property (p_sel0_bit)
        else $error("select 0 not on index bit 0");

    // a rise on select 1 sets index bit 1 one clock later
    property p_sel1_bit;
        @(posedge mclk) disable iff (!resetn)
        $rose(sel1) |=> index_out[1];
    endproperty
    a_sel1_bit: assert property (p_sel1_bit)
        else $error("select 1 not on index bit 1");

    // a fall on select 2 clears index bit 2 one clock later
    property p_sel2_bit;
        @(posedge mclk) disable iff (!resetn)
        $fell(sel2) |=> !index_out[2];
    endproperty
    a_sel2_bit: assert property (p_sel2_bit)
        else $error("select 2 not on index bit 2");

    // a write off the preset addresses leaves presets 0 and 7 unchanged
    property p_monitor_ro;
        @(posedge mclk) disable iff (!resetn)
        (access_phase && pwrite && !addr_preset)
        |=> (preset[0] == $past(preset[0]))
         && (preset[7] == $past(preset[7]))
         && !$past(pslverr && (paddr == PSS_OFF_VALUE));
    endproperty
    a_monitor_ro: assert property (p_monitor_ro)
        else $error("monitor write altered state or raised error");

    // index monitor read returns the index held at the setup edge
    property p_index_read;
        @(posedge mclk) disable iff (!resetn)
        (setup_phase && !pwrite && (paddr == PSS_OFF_INDEX))
        |=> (prdata == {29'h0000_0000, $past(index_out)});
    endproperty
    a_index_read: assert property (p_index_read)
        else $error("index monitor read returned wrong value");

    // out of reset, a stable select pattern keeps the index stable; the
    // first edge after a release is excluded, the index leaves zero there
    property p_index_hold;
        @(posedge mclk) disable iff (!resetn)
        ($past(resetn) && $stable(sel0) && $stable(sel1) && $stable(sel2))
        |=> $stable(index_out);
    endproperty
    a_index_hold: assert property (p_index_hold)
        else $error("index changed without a select change");

    // output and index registers reset to zero, as the presets do, so both start there
    property p_reset_out;
        @(posedge mclk) disable iff (!resetn)
        $rose(resetn) |-> (ref_out == PSS_VAL_RESET)
                       && (index_out == PSS_IDX_RESET);
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("output or index not at reset value after reset");

    // the reference stays inside the legal span at all times
    property p_ref_range;
        @(posedge mclk) disable iff (!resetn)
        1'b1 |-> ($signed(ref_out) >= PSS_VAL_MIN)
              && ($signed(ref_out) <= PSS_VAL_MAX);
    endproperty
    a_ref_range: assert property (p_ref_range)
        else $error("reference output outside the legal span");

    // without a bus write every stored preset keeps its value
    property p_bank_hold;
        @(posedge mclk) disable iff (!resetn)
        !wr_take |=> $stable(sel_bus.bank);
    endproperty
    a_bank_hold: assert property (p_bank_hold)
        else $error("preset changed without a bus write");

    // a full write above the span lands as the upper limit
    property p_clamp_high;
        @(posedge mclk) disable iff (!resetn)
        (wr_take && (pstrb[1:0] == 2'b11)
         && ($signed(pwdata[15:0]) > PSS_VAL_MAX))
        |=> (preset[$past(addr_slot)] == PSS_VAL_MAX);
    endproperty
    a_clamp_high: assert property (p_clamp_high)
        else $error("write above the span not clamped to the limit");

    // a full write below the span lands as the lower limit
    property p_clamp_low;
        @(posedge mclk) disable iff (!resetn)
        (wr_take && (pstrb[1:0] == 2'b11)
         && ($signed(pwdata[15:0]) < PSS_VAL_MIN))
        |=> (preset[$past(addr_slot)] == PSS_VAL_MIN);
    endproperty
    a_clamp_low: assert property (p_clamp_low)
        else $error("write below the span not clamped to the limit");

    // value monitor read returns the output held at the setup edge
    property p_value_read;
        @(posedge mclk) disable iff (!resetn)
        (setup_phase && !pwrite && (paddr == PSS_OFF_VALUE))
        |=> (prdata == {16'h0000, $past(ref_out)});
    endproperty
    a_value_read: assert property (p_value_read)
        else $error("value monitor read returned wrong value");

    // preset read returns the stored word, upper half zero
    property p_preset_read;
        @(posedge mclk) disable iff (!resetn)
        (setup_phase && !pwrite && addr_preset)
        |=> (prdata == {16'h0000, $past(preset[addr_slot])});
    endproperty
    a_preset_read: assert property (p_preset_read)
        else $error("preset read returned wrong value");

    // the index register follows the raw select pattern one clock later
    property p_index_lag;
        @(posedge mclk) disable iff (!resetn)
        1'b1 |=> (index_out == $past(sel_bus.index_in));
    endproperty
    a_index_lag: assert property (p_index_lag)
        else $error("index not registered one clock after the selects");

    // the output is the preset that the raw index picked a clock earlier
    property p_ref_lag;
        @(posedge mclk) disable iff (!resetn)
        1'b1 |=> (ref_out == $past(preset[sel_bus.index_in]));
    endproperty
    a_ref_lag: assert property (p_ref_lag)
        else $error("output is not the preset picked by the index");

    // a write to either monitor is accepted quietly, with no error
    property p_monitor_quiet;
        @(posedge mclk) disable iff (!resetn)
        (access_phase && pwrite
         && ((paddr == PSS_OFF_INDEX) || (paddr == PSS_OFF_VALUE)))
        |-> !pslverr;
    endproperty
    a_monitor_quiet: assert property (p_monitor_quiet)
        else $error("monitor write answered with an error");

endmodule

// ==== testbench/pss_dio_model.sv ====
// digital input terminals that drive the three select lines
`timescale 1ns/1ps
module pss_dio_model
    import pss_pkg::*;
(
    // preset number asked for by the bench
    input  wire logic [2:0] idx_req,
    // select lines toward the selector
    output logic            sel0,
    output logic            sel1,
    output logic            sel2
);
    // plain levels; contact bounce is not modelled
    assign sel0 = idx_req[PSS_SEL0_POS];
    assign sel1 = idx_req[PSS_SEL1_POS];
    assign sel2 = idx_req[PSS_SEL2_POS];
endmodule

// ==== testbench/pss_top_tb.sv ====
// self-checking bench for the preset speed selector
`timescale 1ns/1ps
module pss_top_tb
    import pss_pkg::*;
;
    // clock, reset and bus
    logic        mclk;
    logic        resetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sel0;
    logic        sel1;
    logic        sel2;
    logic [15:0] ref_out;
    logic [2:0]  index_out;
    logic [2:0]  idx_req;
    logic [31:0] rd;
    logic        err;
    int          failures;
    int          checks_done;
    // write data, and what each preset must hold afterwards
    logic [15:0] wr_val [8] = '{16'h03E8, 16'hFC18, 16'h04B0, 16'hFA24,
                                16'h01F4, 16'h0100, 16'hFFFF, 16'h0007};
    logic [15:0] exp_val [8] = '{16'h03E8, 16'hFC18, 16'h03E8, 16'hFC18,
                                 16'h01F4, 16'h01FF, 16'hFFFF, 16'h0007};

    pss_top i_dut (.mclk(mclk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sel0(sel0), .sel1(sel1), .sel2(sel2),
        .ref_out(ref_out), .index_out(index_out));

    pss_dio_model i_dio (.idx_req(idx_req), .sel0(sel0), .sel1(sel1),
        .sel2(sel2));

    // free-running 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic results();
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic [3:0] st);
        @(posedge mclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        pstrb <= st;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset_vals();
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, 4'hF);
            chk({16'h0, rd[15:0]}, 32'h0);
        end
        chk({16'h0, ref_out}, 32'h0);
    endtask

    // bounds, clamping on both sides and a low-byte-only write
    task automatic t_presets();
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 8'(4 * i), {16'h0, wr_val[i]}, 4'hF);
        end
        apb(1'b1, 8'h14, 32'h0000_00FF, 4'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0, 4'hF);
            chk({16'h0, rd[15:0]}, {16'h0, exp_val[i]});
        end
    endtask

    // every index in turn; output must lag the select lines by one edge
    task automatic t_select();
        for (int k = 1; k <= 8; k++) begin
            @(posedge mclk);
            idx_req <= 3'(k % 8);
            #1;
            chk({29'h0, index_out}, 32'((k - 1) % 8));
            @(posedge mclk);
            #1;
            chk({29'h0, index_out}, 32'(k % 8));
            chk({16'h0, ref_out}, {16'h0, exp_val[k % 8]});
            apb(1'b0, PSS_OFF_INDEX, 32'h0, 4'hF);
            chk(rd, 32'(k % 8));
            apb(1'b0, PSS_OFF_VALUE, 32'h0, 4'hF);
            chk(rd, {16'h0, exp_val[k % 8]});
        end
    endtask

    // monitors ignore writes; an unmapped place answers with an error
    task automatic t_monitors();
        apb(1'b1, PSS_OFF_INDEX, 32'h5, 4'hF);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, PSS_OFF_VALUE, 32'h123, 4'hF);
        apb(1'b0, PSS_OFF_INDEX, 32'h0, 4'hF);
        chk(rd, 32'h0);
        apb(1'b0, PSS_OFF_VALUE, 32'h0, 4'hF);
        chk(rd, {16'h0, exp_val[0]});
        apb(1'b0, 8'h30, 32'h0, 4'hF);
        chk({err, rd[30:0]}, 32'h8000_0000);
    endtask

    // a preset rewritten while selected reaches the output one edge on
    task automatic t_live_write();
        @(posedge mclk);
        idx_req <= 3'h4;
        repeat (2) @(posedge mclk);
        apb(1'b1, 8'h10, 32'h0000_0064, 4'hF);
        #1;
        chk({16'h0, ref_out}, 32'h0000_01F4);
        @(posedge mclk);
        #1;
        chk({16'h0, ref_out}, 32'h0000_0064);
    endtask

    // a reset in mid-run returns presets, output and index to zero
    task automatic t_reset_again();
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk({16'h0, ref_out}, 32'h0);
        chk({29'h0, index_out}, 32'h0);
        t_reset_vals();
    endtask

    initial begin
        resetn = 1'b0;
        {paddr, psel, penable, pwrite, pwdata, pstrb} = '0;
        idx_req = 3'h0;
        failures = 0;
        checks_done = 0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        t_reset_vals();
        t_presets();
        t_select();
        t_monitors();
        t_live_write();
        t_reset_again();
        results();
    end

    // a hung handshake ends the run here instead
    initial begin
        #(40 * 5000);
        failures++;
        results();
    end
endmodule
